// File: pkg/nvb_pkg.sv
// shared constants for the host-side controller of a battery-free
// nonvolatile-backed byte-wide static memory; clock assumed 20 MHz here
package nvb_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  // clock is 20 MHz, 50 ns period
  localparam int CLK_PERIOD_NS = 50;
  // access phase times in ns, as the controller chooses them
  localparam int SETUP_NS = 50;
  // five strobe cycles so read data clears the pin filter before capture
  localparam int STROBE_NS = 250;
  localparam int HOLD_NS = 50;
  // least times round up to whole cycles, none below one
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC =
    (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // save request pulse on the busy line, ns and cycles
  localparam int SAVE_PULSE_NS = 100;
  localparam int SAVE_PULSE_CYC =
    (SAVE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  // cycles a pin level needs to pass the three-flop filter
  localparam int SYNC_CYC = 4;
  // reset values of the pins
  localparam logic PIN_IDLE = 1'b1;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  // controller states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_SETUP = 6'b000010,
    ST_STROBE = 6'b000100,
    ST_HOLD = 6'b001000,
    ST_SAVE = 6'b010000,
    ST_WAIT = 6'b100000
  } nvb_state_t;
endpackage : nvb_pkg

// File: rtl/nvb_host.sv
// host controller driving a byte-wide nonvolatile-backed memory by pins
// assumes the busy line has an external pull-up and the bus is resolved
// by the bench from the enable signals
//
// What this block does
// - one 8-bit two-way bus carries data, device drives reads, host writes.
// - the host pulls the low-active select low to address the device.
// - address latches at select fall, and the write strobe writes the bus.
// - pulling the busy line low from outside starts a full save.
`timescale 1ns/10ps
`default_nettype none
module nvb_host (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST,
  // user request port
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic [nvb_pkg::ADDR_W-1:0] i_addr,
  input wire logic [nvb_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_save_req,
  output logic o_busy,
  output logic o_done,
  output logic [nvb_pkg::DATA_W-1:0] o_rdata,
  output logic o_dev_saving,
  // device pins
  output logic [nvb_pkg::ADDR_W-1:0] O_BYTE_ADDR_IN,
  output logic O_SEL_N,
  output logic O_WR_N,
  output logic O_OE_N,
  input wire logic [nvb_pkg::DATA_W-1:0] I_BYTE_BUS_IO,
  output logic [nvb_pkg::DATA_W-1:0] O_BYTE_BUS_IO,
  output logic O_BYTE_BUS_IO_EN_N,
  input wire logic I_SAVE_BUSY_LINE,
  output logic O_SAVE_BUSY_LINE,
  output logic O_SAVE_BUSY_LINE_EN_N
);
  import nvb_pkg::*;
  nvb_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
  logic sel_n_q, sel_n_d, wr_n_q, wr_n_d, oe_n_q, oe_n_d;
  logic den_n_q, den_n_d, sen_n_q, sen_n_d;
  logic busy_q, busy_d, done_q, done_d, saving_q, saving_d;
  logic bus_lvl [DATA_W];
  logic [DATA_W-1:0] bus_in;
  logic line_lvl;

  // read data bits synchronised one by one, so no single bit settles wrong
  genvar g;
  generate
    for (g = 0; g < DATA_W; g++) begin : g_bus
      nvb_sync u_sync (
        .i_clk(I_CLOCK),
        .i_rst(I_RST),
        .i_pin(I_BYTE_BUS_IO[g]),
        .o_level(bus_lvl[g])
      );
      assign bus_in[g] = bus_lvl[g];
    end
  endgenerate

  // busy line level; an open line reads high by the external pull-up
  nvb_sync u_line (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_pin(I_SAVE_BUSY_LINE),
    .o_level(line_lvl)
  );

  // next state of the access sequencer
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    sel_n_d = sel_n_q;
    wr_n_d = wr_n_q;
    oe_n_d = oe_n_q;
    den_n_d = den_n_q;
    sen_n_d = sen_n_q;
    busy_d = busy_q;
    done_d = 1'b0;
    saving_d = ~line_lvl;
    case (st_q)
      ST_IDLE: begin
        // device saving or restoring: hold off, it serves nothing then
        if (i_save_req && line_lvl) begin
          sen_n_d = 1'b0;
          cnt_d = CNT_W'(SAVE_PULSE_CYC - 1);
          busy_d = 1'b1;
          st_d = ST_SAVE;
        end else if (i_req && line_lvl) begin
          wr_d = i_wr;
          addr_d = i_addr;
          wdat_d = i_wdata;
          busy_d = 1'b1;
          cnt_d = CNT_W'(SETUP_CYC - 1);
          st_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // address is stable before select falls, so the latch sees it
        if (cnt_q == '0) begin
          sel_n_d = 1'b0;
          if (wr_q) begin
            wr_n_d = 1'b0;
            den_n_d = 1'b0;
          end else begin
            oe_n_d = 1'b0;
          end
          cnt_d = CNT_W'(STROBE_CYC - 1);
          st_d = ST_STROBE;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      ST_STROBE: begin
        if (cnt_q == '0) begin
          // sample after sync delay already covered by strobe width
          if (!wr_q)
            rdat_d = bus_in;
          wr_n_d = 1'b1;
          oe_n_d = 1'b1;
          sel_n_d = 1'b1;
          cnt_d = CNT_W'(HOLD_CYC - 1);
          st_d = ST_HOLD;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      ST_HOLD: begin
        // keep write data a while past the strobe rise
        if (cnt_q == '0) begin
          den_n_d = 1'b1;
          busy_d = 1'b0;
          done_d = 1'b1;
          st_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      ST_SAVE: begin
        if (cnt_q == '0) begin
          sen_n_d = 1'b1;
          cnt_d = CNT_W'(SYNC_CYC);
          st_d = ST_WAIT;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      ST_WAIT: begin
        // wait for the device's own drive to end the save; the filter
        // lags the pin, so an early look would see the line still high
        if (cnt_q != '0) begin
          cnt_d = cnt_q - CNT_W'(1);
        end else if (line_lvl && sen_n_q) begin
          busy_d = 1'b0;
          done_d = 1'b1;
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // registers of the sequencer and the pins
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b0;
      addr_q <= '0;
      wdat_q <= DATA_RST;
      rdat_q <= DATA_RST;
      sel_n_q <= PIN_IDLE;
      wr_n_q <= PIN_IDLE;
      oe_n_q <= PIN_IDLE;
      den_n_q <= PIN_IDLE;
      sen_n_q <= PIN_IDLE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      saving_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      sel_n_q <= sel_n_d;
      wr_n_q <= wr_n_d;
      oe_n_q <= oe_n_d;
      den_n_q <= den_n_d;
      sen_n_q <= sen_n_d;
      busy_q <= busy_d;
      done_q <= done_d;
      saving_q <= saving_d;
    end
  end

  // outputs straight from flops; busy line only ever driven low
  assign O_BYTE_ADDR_IN = addr_q;
  assign O_SEL_N = sel_n_q;
  assign O_WR_N = wr_n_q;
  assign O_OE_N = oe_n_q;
  assign O_BYTE_BUS_IO = wdat_q;
  assign O_BYTE_BUS_IO_EN_N = den_n_q;
  assign O_SAVE_BUSY_LINE = 1'b0;
  assign O_SAVE_BUSY_LINE_EN_N = sen_n_q;
  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_rdata = rdat_q;
  assign o_dev_saving = saving_q;

  // checks on the pins the host drives
  chk_bus_vs_oe: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    !den_n_q |-> oe_n_q) else $error("host drives bus with oe low");
  chk_strobe_sel: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (!wr_n_q || !oe_n_q) |-> !sel_n_q)
    else $error("strobe without select");
  chk_wr_data: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    $fell(wr_n_q) |-> !den_n_q [*2])
    else $error("write data not held under strobe");
  chk_sel_len: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    $fell(sel_n_q) |-> !sel_n_q [*5] ##1 sel_n_q)
    else $error("select width wrong");
  chk_addr_hold: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    !sel_n_q |-> $stable(addr_q)) else $error("address moved");
  chk_save_pulse: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    $fell(sen_n_q) |-> !sen_n_q [*2] ##1 sen_n_q)
    else $error("save pulse width wrong");
  chk_oe_off: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    $fell(oe_n_q) |-> ##5 oe_n_q) else $error("oe not released");
  chk_idle_save: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    !line_lvl && st_q == ST_IDLE |=> sel_n_q)
    else $error("access while device saving");
endmodule // nvb_host
`default_nettype wire

// File: rtl/nvb_sync.sv
// three-flop synchroniser for one pin level
// assumes the pin is asynchronous to the clock
`timescale 1ns/10ps
`default_nettype none
module nvb_sync (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // pin in, settled level out
  input wire logic i_pin,
  output logic o_level
);
  import nvb_pkg::*;
  logic [2:0] sr_q;
  logic [2:0] sr_d;
  logic lvl_q;
  logic lvl_d;
  // shift; change only counts once stages two and three agree
  always_comb begin
    sr_d = {sr_q[1:0], i_pin};
    lvl_d = (sr_q[1] == sr_q[2]) ? sr_q[2] : lvl_q;
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sr_q <= {3{PIN_IDLE}};
      lvl_q <= PIN_IDLE;
    end else begin
      sr_q <= sr_d;
      lvl_q <= lvl_d;
    end
  end
  assign o_level = lvl_q;
endmodule // nvb_sync
`default_nettype wire

// File: tb/nvb_dev_model.sv
// behavioural byte store with nonvolatile shadow and save-busy line
// assumes the bench resolves bus and busy line from all enables
`timescale 1ns/10ps
`default_nettype none
module nvb_dev_model #(parameter int SAVE_NS = 400) (
  // pins from host, and the power-loss input from the bench
  input wire logic [14:0] i_a,
  input wire logic i_sel_n,
  input wire logic i_wr_n,
  input wire logic i_oe_n,
  input wire logic [7:0] i_bus,
  input wire logic i_line,
  input wire logic i_pwr_loss,
  // pins to host
  output logic [7:0] o_dq,
  output logic o_drv,
  output logic o_pull
);
  logic [7:0] mem [32768];
  logic [7:0] nv [32768];
  logic [14:0] a_q;
  wire logic wr_on;
  // address caught at select fall
  always @(negedge i_sel_n) a_q = i_a;
  // drive only when selected and enabled
  assign o_drv = !i_sel_n && !i_oe_n && i_wr_n;
  assign o_dq = mem[a_q];
  // strobe only counts under select
  assign wr_on = !i_sel_n && !i_wr_n;
  // one process owns both arrays; the byte lands as the strobe ends, so
  // select and strobe falling together cannot hit a stale address
  initial begin
    o_pull = 1'b0;
    for (int i = 0; i < 32768; i++) begin
      nv[i] = 8'hA5;
    end
    mem = nv; // restore before any access
    forever begin
      @(negedge wr_on or negedge i_line or posedge i_pwr_loss);
      if (!i_line || i_pwr_loss) begin
        o_pull = 1'b1;
        nv = mem;
        #SAVE_NS;
        o_pull = 1'b0;
      end else begin
        mem[a_q] = i_bus;
      end
    end
  end
endmodule // nvb_dev_model
`default_nettype wire

// File: tb/nvb_host_tb.sv
// self-checking bench for the host controller with a device model
// assumes the design's contract: one access per done pulse
`timescale 1ns/10ps
`default_nettype none
module nvb_host_tb;
  import nvb_pkg::*;
  logic clk = 0, rst = 1, req = 0, wr = 0, sreq = 0, ploss = 0;
  logic [14:0] addr = '0, pa;
  logic [7:0] wdata = '0, rdata, hd, dq, bus, last = '0;
  logic busy, done, saving, sel_n, wr_n, oe_n, hen_n, hl, hlen_n;
  logic drv, pull, line, seen = 0, seen_clr = 0;
  logic [7:0] refm [32768];
  logic [14:0] al [$];
  logic [31:0] seed = 62434;
  int num_errors = 0, check_count = 0, n;
  always #25 clk = ~clk;
  // wired-low busy line with pull-up
  assign line = (!hlen_n && !hl) || pull ? 1'b0 : 1'b1;
  // released bus shows a changing pattern, not the last value
  assign bus = !hen_n ? hd : drv ? dq : ~last;
  always @(posedge clk) last <= bus;
  always @(posedge clk) seen <= saving || (seen && !seen_clr);
  nvb_host DUT (.I_CLOCK(clk), .I_RST(rst), .i_req(req), .i_wr(wr),
    .i_addr(addr), .i_wdata(wdata), .i_save_req(sreq), .o_busy(busy),
    .o_done(done), .o_rdata(rdata), .o_dev_saving(saving),
    .O_BYTE_ADDR_IN(pa), .O_SEL_N(sel_n), .O_WR_N(wr_n), .O_OE_N(oe_n),
    .I_BYTE_BUS_IO(bus), .O_BYTE_BUS_IO(hd), .O_BYTE_BUS_IO_EN_N(hen_n),
    .I_SAVE_BUSY_LINE(line), .O_SAVE_BUSY_LINE(hl),
    .O_SAVE_BUSY_LINE_EN_N(hlen_n));
  nvb_dev_model M (.i_a(pa), .i_sel_n(sel_n), .i_wr_n(wr_n),
    .i_oe_n(oe_n), .i_bus(bus), .i_line(line), .i_pwr_loss(ploss),
    .o_dq(dq), .o_drv(drv), .o_pull(pull));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one request, then bounded wait for done
  task automatic go(input logic w, s, input logic [14:0] a,
      input logic [7:0] d);
    @(posedge clk);
    req <= !s;
    sreq <= s;
    wr <= w;
    addr <= a;
    wdata <= d;
    n = 0;
    @(posedge clk);
    #1;
    while (busy !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    req <= 1'b0;
    sreq <= 1'b0;
    while (done !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    // a hang counts once and ends the run at the report
    if (n >= 400) begin
      chk("timeout", 0, 1);
      close_out();
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    al = '{15'h0000, 15'h7FFF};
    // boundary and random addresses, written back to back
    for (int i = 0; i < 20; i++) begin
      seed = xs(seed);
      if (i > 1) al.push_back(seed[14:0]);
      refm[al[i]] = seed[22:15];
      go(1'b1, 1'b0, al[i], seed[22:15]);
    end
    foreach (al[i]) begin
      go(1'b0, 1'b0, al[i], 8'h00);
      chk("rdata", refm[al[i]], rdata);
    end
    // host-requested save copies the array
    go(1'b0, 1'b1, 15'h0000, 8'h00);
    chk("saving", 1, seen);
    chk("nv", refm[al[5]], M.nv[al[5]]);
    // power-loss save takes the latest byte and holds off the next read
    seed = xs(seed);
    refm[al[3]] = seed[7:0];
    go(1'b1, 1'b0, al[3], seed[7:0]);
    @(posedge clk);
    ploss <= 1'b1;
    seen_clr <= 1'b1;
    @(posedge clk);
    seen_clr <= 1'b0;
    repeat (2) @(posedge clk);
    ploss <= 1'b0;
    go(1'b0, 1'b0, al[3], 8'h00);
    chk("pl_seen", 1, seen);
    chk("pl_rd", refm[al[3]], rdata);
    chk("pl_nv", refm[al[3]], M.nv[al[3]]);
    close_out();
  end
endmodule // nvb_host_tb
`default_nettype wire
